/* File: rtl/pbhc_pkg.sv */
package pbhc_pkg;
   localparam int          ADDR_W        = 11;
   localparam int          BUF_SIZE      = 2048;
   localparam logic [11:0] TX_TOP        = 12'h800;
   localparam int          BIT_POR       = 0;
   localparam int          BIT_TXSW      = 3;
   localparam int          BIT_RXASW     = 4;
   localparam int          BIT_RXBSW     = 5;
   localparam int          BIT_INTEN     = 6;
   localparam int          BIT_DLCRST    = 7;
   localparam int          BIT_ORDER     = 2;
   localparam int          BIT_XSEL      = 7;
   localparam logic [7:0]  AUX_RESET     = 8'h01;
   localparam logic [3:0]  COLL_LIMIT    = 4'hF;
   localparam logic [1:0]  HDR_DATA_OFS  = 2'h2;
   localparam int          IRQ_PULSE_NS  = 600;
   localparam int          CLK_NS        = 100;
   localparam int          IRQ_PULSE_CYC = (IRQ_PULSE_NS + CLK_NS - 1) / CLK_NS;
   typedef enum logic [1:0] {
      PBHC_IDLE = 2'b00,
      PBHC_SEND = 2'b01,
      PBHC_WAIT = 2'b11
   } pbhc_tx_t;
endpackage : pbhc_pkg

/* File: rtl/pbhc_pulse_stretch.sv */
`timescale 1ns/100ps
`default_nettype none
module pbhc_pulse_stretch #(
   parameter int CYCLES = 7
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // event and stretched output
   input  wire logic trig,
   output var  logic pulse
);
   localparam int CW = $clog2(CYCLES + 1);
   logic [CW-1:0] countReg;

   initial begin
      if (CYCLES < 1) $error("CYCLES must be at least 1");
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         countReg <= '0;
      end else if (trig) begin
         countReg <= CW'(CYCLES);
      end else if (countReg != '0) begin
         countReg <= countReg - 1'b1;
      end
   end

   assign pulse = (countReg != '0);
endmodule // pbhc_pulse_stretch
`default_nettype wire

/* File: rtl/pbhc_handoff_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module pbhc_handoff_ctrl (
   // clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   // host auxiliary command write
   input  wire logic                          auxWrite,
   input  wire logic [7:0]                    auxData,
   // host pointer and collision counter writes
   input  wire logic                          txPtrWrite,
   input  wire logic [pbhc_pkg::ADDR_W-1:0]   txPtrData,
   input  wire logic                          collCountClear,
   // host buffer access
   input  wire logic                          hostTxAccess,
   input  wire logic                          hostRxAAccess,
   input  wire logic                          hostRxBAccess,
   output logic                               hostTxGrant,
   output logic                               hostRxAGrant,
   output logic                               hostRxBGrant,
   // transmit command enables
   input  wire logic                          collIntEnable,
   input  wire logic                          coll16IntEnable,
   // data link controller transmit side
   output logic                               dlcTxStart,
   output logic [pbhc_pkg::ADDR_W-1:0]        dlcTxPtr,
   input  wire logic                          dlcTxDone,
   input  wire logic                          dlcCollision,
   // data link controller receive side
   input  wire logic                          dlcRxDone,
   input  wire logic [4:0]                    dlcRxStatus,
   input  wire logic [pbhc_pkg::ADDR_W-1:0]   dlcRxEnd,
   output logic                               rxHdrWrite,
   output logic                               rxHdrSelB,
   output logic [pbhc_pkg::ADDR_W-1:0]        rxHdrAddr,
   output logic [7:0]                         rxHdrByte,
   output logic [pbhc_pkg::ADDR_W-1:0]        rxDataStart,
   // transceiver selection
   input  wire logic                          xcvrSwitchPin,
   input  wire logic                          extCollision,
   input  wire logic                          intCollision,
   output logic                               useIntegral,
   // status to host
   output logic [7:0]                         auxStatus,
   output logic [1:0]                         txStatus,
   output logic [3:0]                         collCount,
   output logic                               hostIrq
);
   import pbhc_pkg::*;

   logic       xselMeta;
   logic       xselReg;
   logic [7:0] auxReg;
   logic       orderReg;
   logic [3:0] collReg;
   logic       collSeenReg;
   logic       coll16Reg;
   logic       hdrPendReg;
   logic       hdrBReg;
   logic [7:0] hdrLowReg;
   logic [ADDR_W-1:0] startReg;
   logic [ADDR_W-1:0] ptrReg;
   pbhc_tx_t   txState;
   logic       collEvt;
   logic       rxGood;
   logic       rxToA;
   logic       rxToB;
   logic       irqTrig;
   logic       txEnd;

   function automatic logic wr1(input logic [7:0] d, input int b);
      return auxWrite && d[b];
   endfunction

   // selection switch synchroniser
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         xselMeta <= 1'b0;
         xselReg  <= 1'b0;
      end else begin
         xselMeta <= xcvrSwitchPin;
         xselReg  <= xselMeta;
      end
   end
   assign useIntegral = xselReg;
   // selected path, integral or external: own transmit collisions only
   assign collEvt = (txState == PBHC_SEND) &&
                    (xselReg ? intCollision : extCollision)
                    && dlcCollision;

   assign rxToA  = auxReg[BIT_RXASW];
   assign rxToB  = auxReg[BIT_RXBSW] && !rxToA;
   assign rxGood = dlcRxDone && (rxToA || auxReg[BIT_RXBSW]);
   assign txEnd  = (txState == PBHC_SEND) &&
                   (dlcTxDone || (collEvt && collReg == COLL_LIMIT));

   // auxiliary command register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         auxReg <= AUX_RESET;
      end else begin
         auxReg[BIT_DLCRST] <= auxWrite ? auxData[BIT_DLCRST]
                                        : auxReg[BIT_DLCRST];
         auxReg[BIT_INTEN]  <= auxWrite ? auxData[BIT_INTEN]
                                        : auxReg[BIT_INTEN];
         auxReg[1]          <= auxWrite ? auxData[1] : auxReg[1];
         auxReg[2]          <= 1'b0;
         if (wr1(auxData, BIT_POR))
            auxReg[BIT_POR] <= 1'b0;
         // set wins over clear
         if (wr1(auxData, BIT_TXSW))
            auxReg[BIT_TXSW] <= 1'b1;
         else if (txEnd)
            auxReg[BIT_TXSW] <= 1'b0;
         if (wr1(auxData, BIT_RXASW))
            auxReg[BIT_RXASW] <= 1'b1;
         else if (rxGood && rxToA)
            auxReg[BIT_RXASW] <= 1'b0;
         if (wr1(auxData, BIT_RXBSW))
            auxReg[BIT_RXBSW] <= 1'b1;
         else if (rxGood && rxToB)
            auxReg[BIT_RXBSW] <= 1'b0;
      end
   end

   // arrival order: set when A fills after B has filled, cleared when A fills while B still granted
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         orderReg <= 1'b0;
      end else if (rxGood) begin
         orderReg <= rxToB && auxReg[BIT_RXASW] == 1'b0 &&
                     !orderReg ? 1'b0 : orderReg;
         if (rxToA)
            orderReg <= !auxReg[BIT_RXBSW] ? 1'b1 : 1'b0;
         else
            orderReg <= auxReg[BIT_RXASW] ? 1'b1 : orderReg;
      end
   end

   // transmit sequencing and retry
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         txState <= PBHC_IDLE;
      end else begin
         case (txState)
            PBHC_IDLE: begin
               if (auxReg[BIT_TXSW])
                  txState <= PBHC_SEND;
            end
            PBHC_SEND: begin
               if (txEnd)
                  txState <= PBHC_IDLE;
               else if (collEvt)
                  txState <= PBHC_WAIT;
            end
            PBHC_WAIT: begin
               txState <= PBHC_SEND;
            end
            default: txState <= PBHC_IDLE;
         endcase
      end
   end
   assign dlcTxStart = (txState == PBHC_IDLE && auxReg[BIT_TXSW]) ||
                       txState == PBHC_WAIT;

   // transmit pointer and restore on retry
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         startReg <= '0;
         ptrReg   <= '0;
      end else if (txPtrWrite && !auxReg[BIT_TXSW]) begin
         startReg <= txPtrData;
         ptrReg   <= txPtrData;
      end else if (collEvt) begin
         ptrReg   <= startReg;
      end
   end
   assign dlcTxPtr = ptrReg;

   // collision count and status
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         collReg     <= '0;
         collSeenReg <= 1'b0;
         coll16Reg   <= 1'b0;
      end else begin
         if (collEvt)
            collReg <= collReg + 1'b1;
         else if (collCountClear)
            collReg <= '0;
         if (collEvt)
            collSeenReg <= 1'b1;
         else if (wr1(auxData, BIT_TXSW) && !auxReg[BIT_TXSW])
            collSeenReg <= 1'b0;
         if (collEvt && collReg == COLL_LIMIT)
            coll16Reg <= 1'b1;
         else if (wr1(auxData, BIT_TXSW) && !auxReg[BIT_TXSW])
            coll16Reg <= 1'b0;
      end
   end
   assign collCount = collReg;
   assign txStatus  = {coll16Reg, collSeenReg};

   // receive header write: byte 0 then byte 1
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hdrPendReg <= 1'b0;
         hdrBReg    <= 1'b0;
         hdrLowReg  <= '0;
         rxHdrWrite <= 1'b0;
         rxHdrSelB  <= 1'b0;
         rxHdrAddr  <= '0;
         rxHdrByte  <= '0;
      end else begin
         rxHdrWrite <= 1'b0;
         if (rxGood) begin
            rxHdrWrite <= 1'b1;
            rxHdrSelB  <= rxToB;
            rxHdrAddr  <= '0;
            rxHdrByte  <= {dlcRxStatus, dlcRxEnd[10:8]};
            hdrPendReg <= 1'b1;
            hdrBReg    <= rxToB;
            hdrLowReg  <= dlcRxEnd[7:0];
         end else if (hdrPendReg) begin
            rxHdrWrite <= 1'b1;
            rxHdrSelB  <= hdrBReg;
            rxHdrAddr  <= ADDR_W'(1);
            rxHdrByte  <= hdrLowReg;
            hdrPendReg <= 1'b0;
         end
      end
   end
   assign rxDataStart = ADDR_W'(HDR_DATA_OFS);

   // host buffer access only while not granted
   assign hostTxGrant  = hostTxAccess  && !auxReg[BIT_TXSW];
   assign hostRxAGrant = hostRxAAccess && !auxReg[BIT_RXASW];
   assign hostRxBGrant = hostRxBAccess && !auxReg[BIT_RXBSW];

   assign auxStatus = {xselReg, auxReg[6:3], orderReg,
                       auxReg[1], auxReg[BIT_POR]};

   // host interrupt
   assign irqTrig = auxReg[BIT_INTEN] &&
                    (rxGood ||
                     (collEvt && collReg == '0 && collIntEnable) ||
                     (collEvt && collReg == COLL_LIMIT
                      && coll16IntEnable));

   pbhc_pulse_stretch #(
      .CYCLES (IRQ_PULSE_CYC)
   ) uIrq (
      .clk   (clk),
      .rst_n (rst_n),
      .trig  (irqTrig),
      .pulse (hostIrq)
   );
endmodule // pbhc_handoff_ctrl
`default_nettype wire

/* File: bench/pbhc_handoff_ctrl_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module pbhc_handoff_ctrl_properties (
   // watched ports
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        dlcTxStart,
   input wire logic        dlcTxDone,
   input wire logic        dlcCollision,
   input wire logic        dlcRxDone,
   input wire logic [4:0]  dlcRxStatus,
   input wire logic [10:0] dlcRxEnd,
   input wire logic        rxHdrWrite,
   input wire logic [10:0] rxHdrAddr,
   input wire logic [7:0]  rxHdrByte,
   input wire logic [10:0] rxDataStart,
   input wire logic        hostTxGrant,
   input wire logic        useIntegral,
   input wire logic [7:0]  auxStatus,
   input wire logic [1:0]  txStatus,
   input wire logic [3:0]  collCount,
   input wire logic        hostIrq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   tx_kickoff_a: assert property ($rose(auxStatus[3]) |-> ##[0:1] dlcTxStart)
      else $error("no start after switch set");
   done_release_a: assert property (dlcTxDone && auxStatus[3] |-> ##[1:2] !auxStatus[3])
      else $error("switch kept after success");
   coll_sticky_a: assert property (txStatus[0] && auxStatus[3] |=> txStatus[0])
      else $error("collision status dropped");
   coll_retry_a: assert property (dlcCollision && auxStatus[3] && collCount != 4'hF
      |-> ##[1:3] dlcTxStart)
      else $error("no retry after collision");
   coll_count_a: assert property (dlcCollision && auxStatus[3] && collCount != 4'hF
      |=> collCount == $past(collCount) + 4'h1)
      else $error("collision count not advanced");
   give_up_a: assert property (dlcCollision && auxStatus[3] && collCount == 4'hF
      |-> ##[1:2] (!auxStatus[3] && txStatus[1]))
      else $error("no give up at sixteenth collision");
   tx_block_a: assert property (auxStatus[3] |-> !hostTxGrant)
      else $error("host granted transmit buffer");
   hdr_pair_a: assert property (dlcRxDone && (auxStatus[4] || auxStatus[5])
      |=> rxHdrWrite && rxHdrAddr == 11'h0
      && rxHdrByte == {$past(dlcRxStatus), $past(dlcRxEnd[10:8])} ##1 rxHdrWrite
      && rxHdrAddr == 11'h1 && rxHdrByte == $past(dlcRxEnd[7:0], 2))
      else $error("header bytes wrong");
   data_start_a: assert property (rxDataStart == 11'h2)
      else $error("data start not two");
   xsel_status_a: assert property (auxStatus[7] == useIntegral)
      else $error("select status mismatch");
   irq_width_a: assert property ($rose(hostIrq) && !auxStatus[0]
      |-> hostIrq [*6] ##1 !hostIrq)
      else $error("interrupt pulse width wrong");
endmodule // pbhc_handoff_ctrl_properties
bind pbhc_handoff_ctrl pbhc_handoff_ctrl_properties props_u (.clk, .rst_n,
   .dlcTxStart, .dlcTxDone, .dlcCollision, .dlcRxDone, .dlcRxStatus, .dlcRxEnd,
   .rxHdrWrite, .rxHdrAddr, .rxHdrByte, .rxDataStart, .hostTxGrant,
   .useIntegral, .auxStatus, .txStatus, .collCount, .hostIrq);
`default_nettype wire

/* File: bench/pbhc_dlc_model.sv */
`timescale 1ns/100ps
`default_nettype none
module pbhc_dlc_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // controller transmit side
   input  wire logic       dlcTxStart,
   input  wire logic [4:0] collsWanted,
   input  wire logic [3:0] delay,
   output logic            dlcTxDone,
   output logic            dlcCollision
);
   int made;
   // one attempt per start, colliding until the wanted count is reached
   initial begin
      made = 0;
      dlcTxDone = 1'b0;
      dlcCollision = 1'b0;
      forever begin
         @(posedge clk iff (dlcTxStart === 1'b1 && rst_n === 1'b1));
         repeat (delay) @(posedge clk);
         #1;
         if (made < collsWanted) begin
            dlcCollision = 1'b1;
            made = (made == 15) ? 0 : made + 1;
         end else begin
            dlcTxDone = 1'b1;
            made = 0;
         end
         @(posedge clk);
         #1;
         dlcCollision = 1'b0;
         dlcTxDone = 1'b0;
      end
   end
endmodule // pbhc_dlc_model
`default_nettype wire

/* File: bench/pbhc_handoff_ctrl_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module pbhc_handoff_ctrl_bench;
   import pbhc_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, auxWrite = 1'b0, txPtrWrite = 1'b0;
   logic collCountClear = 1'b0, hostTxAccess = 1'b1, hostRxAAccess = 1'b1;
   logic hostRxBAccess = 1'b1, collIntEnable = 1'b0, coll16IntEnable = 1'b0;
   logic dlcRxDone = 1'b0, xcvrSwitchPin = 1'b0, irqSeen;
   logic extCollision = 1'b1, intCollision = 1'b1;
   logic [7:0] auxData = 8'h00, rxHdrByte, auxStatus;
   logic [4:0] dlcRxStatus = 5'h00, collsWanted = 5'h00;
   logic [10:0] txPtrData = 11'h000, dlcRxEnd = 11'h000, ptr;
   logic [10:0] dlcTxPtr, rxHdrAddr, rxDataStart;
   logic [3:0] delay = 4'h4, collCount;
   logic [1:0] txStatus;
   logic hostTxGrant, hostRxAGrant, hostRxBGrant, dlcTxStart, dlcTxDone;
   logic dlcCollision, rxHdrWrite, rxHdrSelB, useIntegral, hostIrq;
   int fails = 0, num_checks = 0, seed = 32'h6143, cyc = 0, starts = 0;
   int corner[4] = '{0, 1, 15, 16};
   always #50 clk = ~clk;
   pbhc_handoff_ctrl dut_u (.*);
   pbhc_dlc_model model_u (.*);
   task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         fails++;
         wrap_up();
      end
   end
   // every start must present the packet's first byte
   always @(posedge clk) if (dlcTxStart === 1'b1) begin
      starts++;
      chk("start pointer", ptr, dlcTxPtr);
   end
   task automatic aux(logic [7:0] d);
      @(negedge clk);
      auxWrite = 1'b1;
      auxData = d;
      @(negedge clk);
      auxWrite = 1'b0;
   endtask
   task automatic tx(int k);
      ptr = 11'(12'h800 - 12'(60 + $unsigned($random(seed)) % 1455));
      collsWanted = 5'(k);
      delay = 4'(4 + $unsigned($random(seed)) % 4);
      {collIntEnable, coll16IntEnable} = 2'($random(seed));
      @(negedge clk);
      txPtrWrite = 1'b1;
      txPtrData = ptr;
      collCountClear = 1'b1;
      @(negedge clk);
      txPtrWrite = 1'b0;
      collCountClear = 1'b0;
      starts = 0;
      aux(8'h08);
      aux(8'h00);
      chk("switch kept", 1, auxStatus[3]);
      txPtrWrite = 1'b1;
      txPtrData = ~ptr;
      @(negedge clk);
      txPtrWrite = 1'b0;
      for (int i = 0; i < 400 && auxStatus[3] !== 1'b0; i++) @(negedge clk);
      chk("attempts", (k == 16) ? 16 : k + 1, starts);
      chk("tx status", {k == 16, k > 0}, txStatus);
      if (k < 16) chk("coll count", k, collCount);
      chk("tx grant back", 1, hostTxGrant);
      $display("tx test with %0d collisions done", k);
   endtask
   // length as the host reads it from status and end offset
   function automatic int hostLen(logic [4:0] st, logic [10:0] ofs);
      if (ofs == 11'h000) return (st[3:0] != 4'h0) ? 0 : 2046;
      if (ofs == 11'h001) return 2047;
      return int'(ofs) - 2;
   endfunction
   task automatic rxPkt(logic b);
      logic [4:0] st;
      logic [10:0] ofs;
      logic [7:0] hdr0;
      st = 5'($random(seed));
      ofs = 11'($random(seed));
      @(negedge clk);
      dlcRxDone = 1'b1;
      dlcRxStatus = st;
      dlcRxEnd = ofs;
      @(negedge clk);
      dlcRxDone = 1'b0;
      hdr0 = rxHdrByte;
      chk("hdr byte0", {b, 1'b1, 6'h00, st, ofs[10:8]},
          {rxHdrSelB, rxHdrWrite, rxHdrAddr[5:0], rxHdrByte});
      irqSeen = hostIrq;
      @(negedge clk);
      chk("hdr byte1", {b, 1'b1, 6'h01, ofs[7:0]},
          {rxHdrSelB, rxHdrWrite, rxHdrAddr[5:0], rxHdrByte});
      chk("pkt length", 16'(hostLen(st, ofs)),
          16'(hostLen(hdr0[7:3], {hdr0[2:0], rxHdrByte})));
      chk("data start", 2, rxDataStart);
      irqSeen |= hostIrq;
      repeat (3) @(negedge clk) irqSeen |= hostIrq;
      chk("rx interrupt", 1, irqSeen);
      repeat (4) @(negedge clk);
   endtask
   initial begin
      xcvrSwitchPin = 1'($random(seed));
      extCollision = !xcvrSwitchPin;
      intCollision = xcvrSwitchPin;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      chk("aux reset", 7'h01, auxStatus[6:0]);
      chk("tx reset", 0, {txStatus, collCount});
      repeat (3) @(negedge clk);
      chk("xcvr status", {2{xcvrSwitchPin}}, {auxStatus[7], useIntegral});
      aux(8'h01);
      chk("power-on cleared", 0, auxStatus[0]);
      for (int i = 0; i < 8; i++)
         tx(i < 4 ? corner[i] : 2 + $unsigned($random(seed)) % 13);
      aux(8'h70);
      chk("rx grants", 0, {hostRxAGrant, hostRxBGrant});
      rxPkt(1'b0);
      chk("A filled", 2'b10, auxStatus[5:4]);
      rxPkt(1'b1);
      chk("A first", 0, {auxStatus[5:4], auxStatus[2]});
      aux(8'h60);
      rxPkt(1'b1);
      aux(8'h50);
      rxPkt(1'b0);
      chk("B first", 1, {auxStatus[5:4], auxStatus[2]});
      chk("rx grant back", 2'b11, {hostRxAGrant, hostRxBGrant});
      $display("rx test done");
      wrap_up();
   end
endmodule // pbhc_handoff_ctrl_bench
`default_nettype wire
